/* tmc_pkg.sv */
`default_nettype none
package tmc_pkg;
   // ==========================================================
   // register map and field layout
   localparam logic [3:0] ADDR_MODE_CTRL   = 4'h0;
   localparam logic [3:0] ADDR_ENABLE_CTRL = 4'h1;
   localparam logic [3:0] ADDR_STATUS      = 4'h2;
   localparam logic [7:0] MODE_CTRL_RESET  = 8'h00;
   localparam logic [7:0] ENABLE_RESET     = 8'h00;
   localparam int         BIT_TUNED        = 7;
   localparam int         BIT_SW_TRIG      = 6;
   localparam int         BIT_EXT_SEL      = 5;
   localparam int         BIT_RUN_EN       = 7;
   localparam logic [7:0] MODE_CTRL_MASK   = 8'he7;
   localparam logic [7:0] ENABLE_MASK      = 8'h87;

   typedef enum logic [2:0] {
      MODE_INTERVAL  = 3'h0,
      MODE_EXT_COUNT = 3'h1,
      MODE_EXT_TRIG  = 3'h2,
      MODE_ONE_SHOT  = 3'h3,
      MODE_PWM       = 3'h4,
      MODE_FREE_RUN  = 3'h5,
      MODE_PULSE_MEAS = 3'h6,
      MODE_PROHIBIT  = 3'h7
   } timer_mode_t;
endpackage
`default_nettype wire

/* tmc_if.sv */
`timescale 1ns/1ns
`default_nettype none
// decoded settings handed from the register file to the core selector
interface tmc_if;
   logic       run_en;
   logic       tuned;
   logic       ext_src;
   logic [2:0] mode;
   logic       trig_pulse;
   modport regs (output run_en, tuned, ext_src, mode, trig_pulse);
   modport core (input run_en, tuned, ext_src, mode, trig_pulse);
endinterface
`default_nettype wire

/* tmc_select.sv */
`timescale 1ns/1ns
`default_nettype none
module tmc_select
   import tmc_pkg::*;
(
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic ce,
   tmc_if.core       cfg,
   input  wire logic int_tick,
   input  wire logic ext_edge,
   input  wire logic master_tick,
   output logic      count_tick_ff,
   output logic      start_trig_ff
);
   // ==========================================================
   // count source selection
   logic src_tick;
   always_comb begin
      if (cfg.mode == MODE_EXT_COUNT || cfg.ext_src) begin
         src_tick = ext_edge;
      end else begin
         src_tick = int_tick;
      end
   end

   // slave units follow the master tick, otherwise own source
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         count_tick_ff <= 1'b0;
      end else if (ce) begin
         count_tick_ff <= cfg.run_en & (cfg.tuned ? master_tick : src_tick);
      end
   end

   // software trigger reaches the core only in the two pulse modes
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         start_trig_ff <= 1'b0;
      end else if (ce) begin
         start_trig_ff <= cfg.trig_pulse & cfg.run_en &
                          (cfg.mode == MODE_ONE_SHOT || cfg.mode == MODE_EXT_TRIG);
      end
   end

   AST_TRIG_MODE: assert property (@(posedge clk) disable iff (!arst_n)
      start_trig_ff |-> ($past(cfg.mode) == MODE_ONE_SHOT || $past(cfg.mode) == MODE_EXT_TRIG))
      else $error("trigger passed in a mode that ignores it");
   AST_EXT_COUNT: assert property (@(posedge clk) disable iff (!arst_n)
      (ce && cfg.run_en && !cfg.tuned && cfg.mode == MODE_EXT_COUNT && ext_edge)
      |=> count_tick_ff)
      else $error("external event count mode missed an edge");
   AST_INT_SRC: assert property (@(posedge clk) disable iff (!arst_n)
      (ce && cfg.run_en && !cfg.tuned && !cfg.ext_src && cfg.mode != MODE_EXT_COUNT)
      |=> count_tick_ff == $past(int_tick))
      else $error("internal source not followed");
   AST_TUNED: assert property (@(posedge clk) disable iff (!arst_n)
      (ce && cfg.run_en && cfg.tuned) |=> count_tick_ff == $past(master_tick))
      else $error("slave did not follow master tick");
endmodule
`default_nettype wire

/* timer_mode_control.sv */
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - holds an 8-bit mode control register steering timer operation.
// - register is read and written as whole byte or single bits.
// - system reset clears the whole register to zero.
// - tuned bit clear runs the timer independently.
// - tuned bit set makes the timer a slave following its master.
// - source-select clear counts the prescaled internal clock.
// - source-select set counts valid external event edges.
// - mode codes 000..011: interval, event count, trigger pulse, one-shot.
// - codes 100..110: PWM, free-run, pulse width; 111 never written.
// - event count mode counts the external input unless the tuned bit is set.
// - rewriting the same value while running is harmless.
// - changing mode or source while running is undefined.
module timer_mode_control
   import tmc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       ce,
   input  wire logic [3:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   input  wire logic       bit_op,
   input  wire logic [2:0] bit_sel,
   input  wire logic       int_tick,
   input  wire logic       ext_edge,
   input  wire logic       master_tick,
   output logic [7:0]      rdata,
   output logic            count_tick,
   output logic            start_trig,
   output logic [2:0]      mode_sel,
   output logic            change_err
);
   // ==========================================================
   // register storage
   logic [7:0] mode_ctrl_ff;
   logic [7:0] enable_ff;
   logic       trig_ff;
   logic       err_ff;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_mode_ctrl;
   logic [7:0] nxt_enable;
   tmc_if      cfg ();

   // merge a byte write or a single-bit write into the old value
   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] d,
                                        input logic bop, input logic [2:0] b,
                                        input logic [7:0] mask);
      logic [7:0] r;
      r = old;
      if (bop) begin
         r[b] = d[0];
      end else begin
         r = d;
      end
      return r & mask;
   endfunction

   always_comb begin
      nxt_mode_ctrl = merge(mode_ctrl_ff, wdata, bit_op, bit_sel, MODE_CTRL_MASK);
      nxt_mode_ctrl[BIT_SW_TRIG] = 1'b0; // trigger bit is a strobe, never stored
      nxt_enable = merge(enable_ff, wdata, bit_op, bit_sel, ENABLE_MASK);
   end

   // mode control register; undefined-change writes still land
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_ctrl_ff <= MODE_CTRL_RESET;
      end else if (ce && wr && addr == ADDR_MODE_CTRL) begin
         mode_ctrl_ff <= nxt_mode_ctrl;
      end
   end

   // timer enable and prescale mirror; stopping lets software reprogram
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         enable_ff <= ENABLE_RESET;
      end else if (ce && wr && addr == ADDR_ENABLE_CTRL) begin
         enable_ff <= nxt_enable;
      end
   end

   // one-cycle trigger strobe from a write of one to the trigger bit
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         trig_ff <= 1'b0;
      end else if (ce) begin
         trig_ff <= wr && addr == ADDR_MODE_CTRL &&
                    (bit_op ? (bit_sel == 3'(BIT_SW_TRIG) && wdata[0])
                            : wdata[BIT_SW_TRIG]);
      end
   end

   // sticky flag: a differing mode or source change while running is reported, same value is not
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         err_ff <= 1'b0;
      end else if (ce) begin
         if (wr && addr == ADDR_MODE_CTRL && enable_ff[BIT_RUN_EN] &&
             nxt_mode_ctrl[5:0] != mode_ctrl_ff[5:0]) begin
            err_ff <= 1'b1;
         end else if (wr && addr == ADDR_STATUS && wdata[0]) begin
            err_ff <= 1'b0;
         end
      end
   end

   // read data one cycle after the strobe; unmapped reads as zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_ff <= 8'h00;
      end else if (ce) begin
         if (rd) begin
            case (addr)
               ADDR_MODE_CTRL:   rdata_ff <= mode_ctrl_ff;
               ADDR_ENABLE_CTRL: rdata_ff <= enable_ff;
               ADDR_STATUS:      rdata_ff <= {7'h00, err_ff};
               default:          rdata_ff <= 8'h00;
            endcase
         end else begin
            rdata_ff <= 8'h00;
         end
      end
   end

   // ==========================================================
   // decoded settings
   assign cfg.run_en     = enable_ff[BIT_RUN_EN];
   assign cfg.tuned      = mode_ctrl_ff[BIT_TUNED];
   assign cfg.ext_src    = mode_ctrl_ff[BIT_EXT_SEL];
   assign cfg.mode       = mode_ctrl_ff[2:0];
   assign cfg.trig_pulse = trig_ff;

   tmc_select u_select (
      .clk           (clk),
      .arst_n        (arst_n),
      .ce            (ce),
      .cfg           (cfg),
      .int_tick      (int_tick),
      .ext_edge      (ext_edge),
      .master_tick   (master_tick),
      .count_tick_ff (count_tick),
      .start_trig_ff (start_trig)
   );

   assign rdata      = rdata_ff;
   assign mode_sel   = mode_ctrl_ff[2:0];
   assign change_err = err_ff;

   AST_RESET_ZERO: assert property (@(posedge clk)
      $rose(arst_n) |-> mode_ctrl_ff == 8'h00)
      else $error("mode register not zero after reset");
   AST_BYTE_WRITE: assert property (@(posedge clk) disable iff (!arst_n)
      (ce && wr && !bit_op && addr == ADDR_MODE_CTRL)
      |=> mode_ctrl_ff == ($past(wdata) & 8'ha7))
      else $error("byte write not stored");
   AST_BIT_WRITE: assert property (@(posedge clk) disable iff (!arst_n)
      (ce && wr && bit_op && addr == ADDR_MODE_CTRL && bit_sel == 3'h5)
      |=> mode_ctrl_ff[5] == $past(wdata[0]))
      else $error("bit write not stored");
   AST_READ_BACK: assert property (@(posedge clk) disable iff (!arst_n)
      (ce && rd && addr == ADDR_MODE_CTRL) |=> rdata == $past(mode_ctrl_ff))
      else $error("read data wrong");
   AST_SAME_OK: assert property (@(posedge clk) disable iff (!arst_n)
      (ce && wr && !bit_op && addr == ADDR_MODE_CTRL && !change_err &&
       (wdata[5:0] & 6'h27) == mode_ctrl_ff[5:0]) |=> !change_err)
      else $error("identical rewrite flagged");

   // ==========================================================
   // qualified strobes shared by the checks below
   logic wr_mode;
   logic wr_mode_byte;
   logic wr_enable;
   logic wr_status;
   logic running;

   // a low clock enable voids every access, so ce is folded in here once
   assign wr_mode      = ce && wr && addr == ADDR_MODE_CTRL;
   assign wr_mode_byte = wr_mode && !bit_op;
   assign wr_enable    = ce && wr && addr == ADDR_ENABLE_CTRL;
   assign wr_status    = ce && wr && addr == ADDR_STATUS;
   assign running      = enable_ff[BIT_RUN_EN];

   // the two modes in which a software trigger means something
   function automatic logic pulse_mode(input logic [2:0] md);
      return md == MODE_ONE_SHOT || md == MODE_EXT_TRIG;
   endfunction

   // ==========================================================
   // storage checks
   // reserved positions and the strobe position never hold a one
   AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!arst_n)
      mode_ctrl_ff[4:3] == 2'b00 && !mode_ctrl_ff[BIT_SW_TRIG])
      else $error("reserved mode bits not zero");

   // only a qualified write moves the register; ce low freezes it
   AST_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
      !wr_mode |=> mode_ctrl_ff == $past(mode_ctrl_ff))
      else $error("mode register moved without a write");

   // a single-bit write to the tuned bit leaves the rest alone
   AST_BIT_TUNED: assert property (@(posedge clk) disable iff (!arst_n)
      (wr_mode && bit_op && bit_sel == 3'h7)
      |=> mode_ctrl_ff[7] == $past(wdata[0]) &&
          mode_ctrl_ff[5:0] == $past(mode_ctrl_ff[5:0]))
      else $error("tuned bit write disturbed other bits");

   // a single-bit write into the mode field touches that bit only
   AST_BIT_MODE0: assert property (@(posedge clk) disable iff (!arst_n)
      (wr_mode && bit_op && bit_sel == 3'h0)
      |=> mode_ctrl_ff[0] == $past(wdata[0]) &&
          mode_ctrl_ff[7:1] == $past(mode_ctrl_ff[7:1]))
      else $error("mode bit write disturbed other bits");

   // the mode field shows on mode_sel right after a byte write
   AST_MODE_OUT: assert property (@(posedge clk) disable iff (!arst_n)
      wr_mode_byte |=> mode_sel == $past(wdata[2:0]))
      else $error("mode field not taken from the write");

   // enable mirror keeps run enable and prescale bits only
   AST_ENABLE_WRITE: assert property (@(posedge clk) disable iff (!arst_n)
      (wr_enable && !bit_op) |=> enable_ff == ($past(wdata) & 8'h87))
      else $error("enable mirror write not stored");

   // the mirror moves on its own address only, so a stop sticks
   AST_ENABLE_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
      !wr_enable |=> enable_ff == $past(enable_ff))
      else $error("enable mirror moved without a write");

   // ==========================================================
   // read port checks
   // read data are zero after every clock-enabled cycle that has no read
   AST_READ_IDLE: assert property (@(posedge clk) disable iff (!arst_n)
      (ce && !rd) |=> rdata == 8'h00)
      else $error("read data not idle");

   // status read: sticky flag in bit 0, zeros above
   AST_READ_STATUS: assert property (@(posedge clk) disable iff (!arst_n)
      (ce && rd && addr == ADDR_STATUS) |=> rdata == {7'h00, $past(change_err)})
      else $error("status read wrong");

   // the enable mirror reads back as stored
   AST_READ_ENABLE: assert property (@(posedge clk) disable iff (!arst_n)
      (ce && rd && addr == ADDR_ENABLE_CTRL) |=> rdata == $past(enable_ff))
      else $error("enable read wrong");

   // unmapped addresses read as zero
   AST_READ_UNMAPPED: assert property (@(posedge clk) disable iff (!arst_n)
      (ce && rd && addr > ADDR_STATUS) |=> rdata == 8'h00)
      else $error("unmapped read not zero");

   // the strobe bit is never seen on a read, even just after a trigger
   AST_READ_NO_TRIG: assert property (@(posedge clk) disable iff (!arst_n)
      (ce && rd && addr == ADDR_MODE_CTRL) |=> !rdata[BIT_SW_TRIG])
      else $error("trigger bit read back");

   // every output is idle on the first edge after reset
   AST_RESET_OUTS: assert property (@(posedge clk)
      $rose(arst_n) |-> rdata == 8'h00 && !change_err && !start_trig && !count_tick)
      else $error("outputs not idle after reset");

   // ==========================================================
   // software trigger checks
   // trigger with a pulse mode while running reaches the core two edges on
   AST_TRIG_PASS: assert property (@(posedge clk) disable iff (!arst_n)
      (wr_mode_byte && wdata[BIT_SW_TRIG] && running && pulse_mode(wdata[2:0])) ##1 ce
      |=> start_trig)
      else $error("trigger lost in a pulse mode");

   // in every other mode the write of one is ignored
   AST_TRIG_IGNORED: assert property (@(posedge clk) disable iff (!arst_n)
      (wr_mode_byte && wdata[BIT_SW_TRIG] && !pulse_mode(wdata[2:0])) ##1 ce
      |=> !start_trig)
      else $error("trigger passed in a non-pulse mode");

   // a stopped timer never starts, whatever the mode
   AST_TRIG_STOPPED: assert property (@(posedge clk) disable iff (!arst_n)
      (wr_mode && !running) ##1 ce |=> !start_trig)
      else $error("trigger passed while stopped");

   // no write, no trigger: the strobe is never left over from an old write
   AST_TRIG_NEEDS_WRITE: assert property (@(posedge clk) disable iff (!arst_n)
      (ce && !wr) ##1 ce |=> !start_trig)
      else $error("trigger without a write");

   // ==========================================================
   // change flag checks
   // a new mode code while running is flagged
   AST_ERR_SET: assert property (@(posedge clk) disable iff (!arst_n)
      (wr_mode_byte && running && wdata[2:0] != mode_ctrl_ff[2:0]) |=> change_err)
      else $error("mode change while running not flagged");

   // so is a new count source while running
   AST_ERR_SRC: assert property (@(posedge clk) disable iff (!arst_n)
      (wr_mode_byte && running && wdata[BIT_EXT_SEL] != mode_ctrl_ff[BIT_EXT_SEL])
      |=> change_err)
      else $error("source change while running not flagged");

   // writes to a stopped timer are always legal
   AST_ERR_STOPPED: assert property (@(posedge clk) disable iff (!arst_n)
      (wr_mode && !running && !change_err) |=> !change_err)
      else $error("write to stopped timer flagged");

   // the flag stands until software clears it
   AST_ERR_STICKY: assert property (@(posedge clk) disable iff (!arst_n)
      (change_err && !(wr_status && wdata[0])) |=> change_err)
      else $error("change flag dropped by itself");

   // a write of one to status bit 0 clears it
   AST_ERR_CLEAR: assert property (@(posedge clk) disable iff (!arst_n)
      (wr_status && wdata[0]) |=> !change_err)
      else $error("change flag not cleared");

   // ==========================================================
   // count source checks at the top
   // a stopped timer sends no count tick
   AST_STOPPED_QUIET: assert property (@(posedge clk) disable iff (!arst_n)
      (ce && !running) |=> !count_tick)
      else $error("count tick while stopped");

   // source-select set follows the event input
   AST_EXT_SEL: assert property (@(posedge clk) disable iff (!arst_n)
      (ce && running && !mode_ctrl_ff[BIT_TUNED] && mode_ctrl_ff[BIT_EXT_SEL])
      |=> count_tick == $past(ext_edge))
      else $error("event source not followed");

   // event count mode ignores the internal tick even with source-select clear
   AST_EVENT_MODE: assert property (@(posedge clk) disable iff (!arst_n)
      (ce && running && !mode_ctrl_ff[BIT_TUNED] && mode_ctrl_ff[2:0] == MODE_EXT_COUNT &&
       !ext_edge) |=> !count_tick)
      else $error("event count mode took the internal tick");

   // a slave unit counts nothing while its master is silent
   AST_SLAVE_QUIET: assert property (@(posedge clk) disable iff (!arst_n)
      (ce && running && mode_ctrl_ff[BIT_TUNED] && !master_tick) |=> !count_tick)
      else $error("slave counted without its master");

   // independent unit ignores the master tick entirely
   AST_INDEPENDENT: assert property (@(posedge clk) disable iff (!arst_n)
      (ce && running && !mode_ctrl_ff[BIT_TUNED] && !mode_ctrl_ff[BIT_EXT_SEL] &&
       mode_ctrl_ff[2:0] != MODE_EXT_COUNT && !int_tick) |=> !count_tick)
      else $error("independent unit followed the master");
endmodule
`default_nettype wire

/* timer_mode_control_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module timer_mode_control_tb_top;
   import tmc_pkg::*;
   // ======================================================
   // stimulus and observed signals
   logic        clk, arst_n, ce, wr, rd, bit_op, int_tick, ext_edge, master_tick;
   logic [3:0]  addr;
   logic [7:0]  wdata, rdata, m, r;
   logic [2:0]  bit_sel, mode_sel, b;
   logic        count_tick, start_trig, change_err, e;
   logic [31:0] s = 32'h23;
   int          n_fail = 0;
   int          checked = 0;
   // {enable reg, mode reg}; the last entry checks that a stopped timer stays quiet
   // this unit has a master to follow, so the tuned entry is legal here
   logic [15:0] cfg [6] = '{16'h8000, 16'h8020, 16'h8001, 16'h8080, 16'h8006, 16'h0020};

   timer_mode_control i_timer_mode_control (.clk, .arst_n, .ce, .addr, .wdata, .wr, .rd,
      .bit_op, .bit_sel, .int_tick, .ext_edge, .master_tick, .rdata, .count_tick,
      .start_trig, .mode_sel, .change_err);

   // free-running 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ======================================================
   // helpers
   function automatic logic [7:0] rnd();
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s[7:0];
   endfunction

   // tuned wins, then event input (forced in event count mode), else prescaled tick
   function automatic logic src(logic [7:0] c, logic it, logic ee, logic mt);
      return c[BIT_TUNED] ? mt : ((c[BIT_EXT_SEL] || c[2:0] == MODE_EXT_COUNT) ? ee : it);
   endfunction

   task automatic cmp(string n, logic [7:0] x, logic [7:0] y);
      checked++;
      if (y !== x) begin
         n_fail++;
         $display("Error %s expected %h seen %h", n, x, y);
      end
   endtask

   task automatic wreg(logic [3:0] a, logic [7:0] d, logic bo = 1'b0, logic [2:0] bs = 3'h0);
      @(posedge clk);
      addr <= a; wdata <= d; wr <= 1'b1; bit_op <= bo; bit_sel <= bs;
      @(posedge clk);
      wr <= 1'b0;
      bit_op <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe, so look there
   task automatic rreg(logic [3:0] a, logic [7:0] x);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 cmp("rdata", x, rdata);
   endtask

   task automatic end_of_test();
      if (n_fail == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ======================================================
   // main sequence
   initial begin
      {arst_n, ce, wr, rd, bit_op, int_tick, ext_edge, master_tick} = 8'h00;
      addr = 4'h0; wdata = 8'h00; bit_sel = 3'h0;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      ce <= 1'b1;
      rreg(ADDR_MODE_CTRL, MODE_CTRL_RESET);
      cmp("mode_sel", 8'h00, {5'h0, mode_sel});
      // byte writes while stopped; code 111 is never written by software
      repeat (30) begin
         m = rnd();
         if (&m[2:0]) m[2] = 1'b0;
         wreg(ADDR_MODE_CTRL, m);
         rreg(ADDR_MODE_CTRL, m & 8'ha7);
         cmp("mode_sel", {5'h0, m[2:0]}, {5'h0, mode_sel});
      end
      m = m & 8'ha7;
      repeat (24) begin
         r = rnd();
         b = r[2:0];
         if (b != 3'h3 && b != 3'h4 && b != 3'h6) m[b] = r[7];
         if (&m[2:0]) begin
            m[b] = 1'b0;
            r[7] = 1'b0;
         end
         wreg(ADDR_MODE_CTRL, {7'h0, r[7]}, 1'b1, b);
         rreg(ADDR_MODE_CTRL, m);
      end
      // frozen clock enable must drop the write
      ce <= 1'b0;
      wreg(ADDR_MODE_CTRL, 8'h05);
      ce <= 1'b1;
      rreg(ADDR_MODE_CTRL, m);
      wreg(4'hf, 8'hff);
      rreg(4'hf, 8'h00);
      rreg(ADDR_MODE_CTRL, m);
      // count source per setting, random ticks on all three sources
      foreach (cfg[i]) begin
         wreg(ADDR_ENABLE_CTRL, 8'h00);
         wreg(ADDR_MODE_CTRL, cfg[i][7:0]);
         wreg(ADDR_ENABLE_CTRL, cfg[i][15:8]);
         e = cfg[i][15] & src(cfg[i][7:0], int_tick, ext_edge, master_tick);
         repeat (20) begin
            @(posedge clk);
            m = rnd();
            int_tick <= m[0]; ext_edge <= m[1]; master_tick <= m[2];
            #1 cmp("count_tick", {7'h0, e}, {7'h0, count_tick});
            e = cfg[i][15] & src(cfg[i][7:0], m[0], m[1], m[2]);
         end
      end
      // software trigger in mode codes 000..110, rewriting the held mode while running
      for (int k = 0; k < 7; k++) begin
         wreg(ADDR_ENABLE_CTRL, 8'h00);
         wreg(ADDR_MODE_CTRL, k[7:0]);
         wreg(ADDR_ENABLE_CTRL, 8'h80);
         wreg(ADDR_MODE_CTRL, 8'h40 | k[7:0]);
         @(posedge clk);
         #1 cmp("start_trig", {7'h0, k == 2 || k == 3}, {7'h0, start_trig});
         cmp("change_err", 8'h00, {7'h0, change_err});
      end
      // a real change while running is flagged, then stop and reprogram
      rreg(ADDR_ENABLE_CTRL, 8'h80);
      wreg(ADDR_MODE_CTRL, 8'h01);
      rreg(ADDR_STATUS, 8'h01);
      wreg(ADDR_STATUS, 8'h01);
      rreg(ADDR_STATUS, 8'h00);
      // a changed count source alone is flagged as well
      wreg(ADDR_MODE_CTRL, 8'h21);
      rreg(ADDR_STATUS, 8'h01);
      wreg(ADDR_STATUS, 8'h01);
      wreg(ADDR_ENABLE_CTRL, 8'h00);
      wreg(ADDR_MODE_CTRL, 8'h03);
      rreg(ADDR_STATUS, 8'h00);
      rreg(ADDR_MODE_CTRL, 8'h03);
      end_of_test();
   end
endmodule
`default_nettype wire
